// *** aecr_adc_model.sv ***
`timescale 1ns/100ps
module aecr_adc_model
(
  input wire logic clk_i, // Clock.
  output logic enc_valid_o, // Encoder strobe.
  output logic [95:0] enc_o, // U P/N, V P/N, W P/N, 16 bits each.
  output logic cur_valid_o, // Current strobe.
  output logic [47:0] cur_o // U, V, W raw currents.
);
  // Data is only valid with its strobe; afterwards the inverse stands so stale use shows.
  initial
  begin
    enc_valid_o = 1'b0;
    enc_o = 96'h0;
    cur_valid_o = 1'b0;
    cur_o = 48'h0;
  end
  task send_enc(input logic [95:0] d);
    @(posedge clk_i);
    enc_valid_o <= 1'b1;
    enc_o <= d;
    @(posedge clk_i);
    enc_valid_o <= 1'b0;
    enc_o <= ~d;
  endtask
  task send_cur(input logic [47:0] d);
    @(posedge clk_i);
    cur_valid_o <= 1'b1;
    cur_o <= d;
    @(posedge clk_i);
    cur_valid_o <= 1'b0;
    cur_o <= ~d;
  endtask
endmodule // aecr_adc_model

// *** aecr_apb_slave.v ***
`timescale 1ns/100ps

module aecr_apb_slave
(
  input wire clk_i, // System clock.
  input wire rst_n_i, // Asynchronous reset, active low.
  input wire psel_i, // APB select.
  input wire penable_i, // APB enable.
  input wire pwrite_i, // APB direction.
  input wire [11:0] paddr_i, // APB byte address.
  input wire [31:0] rd_data_i, // Read data for the current index.
  input wire rd_hit_i, // Current index is mapped.
  output wire [7:0] idx_o, // Word index of the transfer.
  output wire wr_en_o, // Write takes effect at this edge.
  output reg pready_o, // APB ready.
  output reg pslverr_o, // APB error.
  output reg [31:0] prdata_o // APB read data.
);

  wire aligned;
  wire access;

  assign idx_o = paddr_i[9:2];
  assign aligned = (paddr_i[1:0] == 2'b00) && (paddr_i[11:10] == 2'b00);
  assign access = psel_i && penable_i;
  // Writes land only at the edge where the master samples ready high.
  assign wr_en_o = access && pready_o && pwrite_i && aligned && rd_hit_i;

  // One wait state registers the answer so every bus output comes from a flop.
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h00000000;
    end
    else if (access && !pready_o)
    begin
      pready_o <= 1'b1;
      pslverr_o <= !(aligned && rd_hit_i);
      prdata_o <= (!pwrite_i && aligned && rd_hit_i) ? rd_data_i : 32'h00000000;
    end
    else
    begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end
  end

endmodule // aecr_apb_slave

// *** aecr_corrector.v ***
`timescale 1ns/100ps
`include "aecr_defines.vh"

module aecr_corrector
(
  input wire clk_i, // System clock.
  input wire rst_n_i, // Asynchronous reset, active low.
  input wire valid_i, // Raw sample strobe.
  input wire [15:0] raw_i, // Raw unsigned sample.
  input wire [15:0] offset_i, // Offset, added as two's complement.
  input wire [15:0] scale_i, // Signed scale factor.
  output reg valid_o, // Corrected sample strobe.
  output reg [15:0] value_o // Corrected signed sample.
);

  wire signed [16:0] centred;
  wire signed [16:0] sum;
  wire signed [33:0] product;
  wire signed [33:0] shifted;
  wire [15:0] saturated;

  // The raw sample is moved to a signed midscale before the offset is added.
  assign centred = $signed({~raw_i[15], ~raw_i[15], raw_i[14:0]});
  assign sum = centred + $signed({offset_i[15], offset_i});
  assign product = sum * $signed({{2{scale_i[15]}}, scale_i});
  assign shifted = product >>> `AECR_SCALE_SHIFT;

  // Saturation keeps a large gain from wrapping a peak into the opposite sign.
  assign saturated = (shifted > 34'sd32767) ? 16'h7fff :
                     (shifted < -34'sd32768) ? 16'h8000 : shifted[15:0];

  // The result is registered so that every consumer sees the same sample.
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      valid_o <= 1'b0;
      value_o <= 16'h0000;
    end
    else
    begin
      valid_o <= valid_i;
      if (valid_i)
        value_o <= saturated;
    end
  end

endmodule // aecr_corrector

// *** aecr_defines.vh ***
`ifndef AECR_DEFINES_VH
`define AECR_DEFINES_VH

// Register word indices; the byte address on the bus is four times the index.
`define AECR_IDX_INPUT_CONFIG 8'h0a
`define AECR_IDX_ENC_CAL0 8'h0d
`define AECR_IDX_ENC_CAL1 8'h0e
`define AECR_IDX_ENC_CAL2 8'h0f
`define AECR_IDX_ROUTING 8'h11
`define AECR_IDX_CUR_WY_UX 8'h12
`define AECR_IDX_CUR_V 8'h13
`define AECR_IDX_ENC_WY_UX 8'h15
`define AECR_IDX_ENC_VN 8'h16
`define AECR_IDX_CUR_CAL_U 8'h20
`define AECR_IDX_CUR_CAL_V 8'h21
`define AECR_IDX_CUR_CAL_W 8'h22

// Field positions of a calibration word.
`define AECR_OFFSET_LSB 0
`define AECR_SCALE_LSB 16

// Field positions of the routing word, one byte per logical channel.
`define AECR_SEL0_LSB 0
`define AECR_SEL1_LSB 8
`define AECR_SEL2_LSB 16

// Field positions of the input configuration word for the three encoder inputs.
`define AECR_CFG_U_LSB 20
`define AECR_CFG_V_LSB 24
`define AECR_CFG_W_LSB 28

// Source selector codes.
`define AECR_SRC_U 8'h00
`define AECR_SRC_V 8'h01
`define AECR_SRC_W 8'h02

// Input configuration codes.
`define AECR_CFG_DIFF 4'h0
`define AECR_CFG_GND_INN 4'h1
`define AECR_CFG_QUARTER_A 4'h2
`define AECR_CFG_THREE_Q_A 4'h3
`define AECR_CFG_INP_GND 4'h4
`define AECR_CFG_HALF 4'h5
`define AECR_CFG_QUARTER_B 4'h6
`define AECR_CFG_THREE_Q_B 4'h7

// Fixed reference levels as raw samples.
`define AECR_LVL_QUARTER 16'h4000
`define AECR_LVL_HALF 16'h8000
`define AECR_LVL_THREE_Q 16'hc000

// Reset values.
`define AECR_RST_CAL 32'h01000000
`define AECR_RST_ROUTING 32'h00020100
`define AECR_RST_INPUT_CONFIG 32'h00000000

// A scale of 256 is unity gain.
`define AECR_SCALE_SHIFT 8

`endif

// *** aecr_top.v ***
// Chosen here: the APB slave port.
`timescale 1ns/100ps
`include "aecr_defines.vh"

// Summary of operation
// - Channel offset is signed 16 bits, 15:0.
// - Channel scale is signed 16 bits, 31:16.
// - Calibration words 0x0D-0x0F serve channels 0-2.
// - Routing register maps physical inputs to channels.
// - Codes 0,1,2 pick U, V, W inputs.
// - Currents U and W readable in one word.
// - Readback equals values driving field oriented control.
// - Current V readable alone in bits 15:0.
// - Corrected encoder values readable, feed interpolator.
module aecr_top
(
  input wire MCLK_I, // System clock, 250 MHz.
  input wire RSTN_I, // Asynchronous reset, active low.
  input wire PSEL_I, // APB select.
  input wire PENABLE_I, // APB enable.
  input wire PWRITE_I, // APB direction, high for write.
  input wire [11:0] PADDR_I, // APB byte address.
  input wire [31:0] PWDATA_I, // APB write data.
  output wire PREADY_O, // APB ready.
  output wire PSLVERR_O, // APB error for unmapped or unaligned access.
  output wire [31:0] PRDATA_O, // APB read data.
  input wire ENC_VALID_I, // Encoder sample strobe from the converter.
  input wire [15:0] ENC_U_P_I, // Encoder U/X positive sample.
  input wire [15:0] ENC_U_N_I, // Encoder U/X negative sample.
  input wire [15:0] ENC_V_P_I, // Encoder V/N positive sample.
  input wire [15:0] ENC_V_N_I, // Encoder V/N negative sample.
  input wire [15:0] ENC_W_P_I, // Encoder W/Y positive sample.
  input wire [15:0] ENC_W_N_I, // Encoder W/Y negative sample.
  input wire CUR_VALID_I, // Current sample strobe from the converter.
  input wire [15:0] CUR_U_RAW_I, // Raw U/X phase current.
  input wire [15:0] CUR_V_RAW_I, // Raw V phase current.
  input wire [15:0] CUR_W_RAW_I, // Raw W/Y phase current.
  output wire ENC_VALID_O, // Corrected encoder strobe.
  output wire [15:0] ENC_CH0_O, // Corrected channel 0 to interpolator.
  output wire [15:0] ENC_CH1_O, // Corrected channel 1 to interpolator.
  output wire [15:0] ENC_CH2_O, // Corrected channel 2 to interpolator.
  output wire CUR_VALID_O, // Corrected current strobe.
  output wire [15:0] CUR_U_O, // Scaled U/X current to control loop.
  output wire [15:0] CUR_V_O, // Scaled V current to control loop.
  output wire [15:0] CUR_W_O // Scaled W/Y current to control loop.
);

  reg [31:0] enc_cal_reg [0:2];
  reg [31:0] cur_cal_reg [0:2];
  reg [31:0] routing_reg;
  reg [31:0] input_config_reg;
  reg [31:0] rd_data;
  reg rd_hit;
  reg [47:0] phys_raw;
  reg [47:0] sel_raw;
  wire [7:0] idx;
  wire wr_en;
  wire [2:0] enc_valid;
  wire [2:0] cur_valid;
  wire [47:0] enc_value;
  wire [47:0] cur_value;
  wire [47:0] cur_raw;
  wire [23:0] routing_sel;
  wire [11:0] input_cfg;
  wire [47:0] enc_p;
  wire [47:0] enc_n;
  integer i;
  integer j;

  assign routing_sel = routing_reg[23:0];
  assign input_cfg = input_config_reg[31:20];
  assign enc_p = {ENC_W_P_I, ENC_V_P_I, ENC_U_P_I};
  assign enc_n = {ENC_W_N_I, ENC_V_N_I, ENC_U_N_I};
  assign cur_raw = {CUR_W_RAW_I, CUR_V_RAW_I, CUR_U_RAW_I};

  aecr_apb_slave u_apb
  (
    .clk_i(MCLK_I),
    .rst_n_i(RSTN_I),
    .psel_i(PSEL_I),
    .penable_i(PENABLE_I),
    .pwrite_i(PWRITE_I),
    .paddr_i(PADDR_I),
    .rd_data_i(rd_data),
    .rd_hit_i(rd_hit),
    .idx_o(idx),
    .wr_en_o(wr_en),
    .pready_o(PREADY_O),
    .pslverr_o(PSLVERR_O),
    .prdata_o(PRDATA_O)
  );

  // Register writes; read-only words accept the write silently and keep their value.
  always @(posedge MCLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      for (i = 0; i < 3; i = i + 1)
      begin
        enc_cal_reg[i] <= `AECR_RST_CAL;
        cur_cal_reg[i] <= `AECR_RST_CAL;
      end
      routing_reg <= `AECR_RST_ROUTING;
      input_config_reg <= `AECR_RST_INPUT_CONFIG;
    end
    else if (wr_en)
    begin
      case (idx)
        `AECR_IDX_ENC_CAL0: enc_cal_reg[0] <= PWDATA_I;
        `AECR_IDX_ENC_CAL1: enc_cal_reg[1] <= PWDATA_I;
        `AECR_IDX_ENC_CAL2: enc_cal_reg[2] <= PWDATA_I;
        `AECR_IDX_CUR_CAL_U: cur_cal_reg[0] <= PWDATA_I;
        `AECR_IDX_CUR_CAL_V: cur_cal_reg[1] <= PWDATA_I;
        `AECR_IDX_CUR_CAL_W: cur_cal_reg[2] <= PWDATA_I;
        `AECR_IDX_ROUTING: routing_reg <= {8'h00, PWDATA_I[23:0]};
        `AECR_IDX_INPUT_CONFIG: input_config_reg <= {PWDATA_I[31:20], 20'h00000};
        default: routing_reg <= routing_reg;
      endcase
    end
  end

  // Read decode; the readback comes from the same flops that drive the outputs.
  always @*
  begin
    rd_hit = 1'b1;
    rd_data = 32'h00000000;
    case (idx)
      `AECR_IDX_ENC_CAL0: rd_data = enc_cal_reg[0];
      `AECR_IDX_ENC_CAL1: rd_data = enc_cal_reg[1];
      `AECR_IDX_ENC_CAL2: rd_data = enc_cal_reg[2];
      `AECR_IDX_CUR_CAL_U: rd_data = cur_cal_reg[0];
      `AECR_IDX_CUR_CAL_V: rd_data = cur_cal_reg[1];
      `AECR_IDX_CUR_CAL_W: rd_data = cur_cal_reg[2];
      `AECR_IDX_ROUTING: rd_data = routing_reg;
      `AECR_IDX_INPUT_CONFIG: rd_data = input_config_reg;
      `AECR_IDX_CUR_WY_UX: rd_data = {cur_value[47:32], cur_value[15:0]};
      `AECR_IDX_CUR_V: rd_data = {16'h0000, cur_value[31:16]};
      `AECR_IDX_ENC_WY_UX: rd_data = {enc_value[47:32], enc_value[15:0]};
      `AECR_IDX_ENC_VN: rd_data = {16'h0000, enc_value[31:16]};
      default: rd_hit = 1'b0;
    endcase
  end

  // Each physical input picks its source; fixed references let software
  // calibrate the converter path without the encoder connected.
  always @*
  begin
    phys_raw = 48'h000000000000;
    for (j = 0; j < 3; j = j + 1)
    begin
      case (input_cfg[j*4 +: 4])
        `AECR_CFG_GND_INN: phys_raw[j*16 +: 16] = ~enc_n[j*16 +: 16];
        `AECR_CFG_INP_GND: phys_raw[j*16 +: 16] = enc_p[j*16 +: 16];
        `AECR_CFG_QUARTER_A, `AECR_CFG_QUARTER_B: phys_raw[j*16 +: 16] = `AECR_LVL_QUARTER;
        `AECR_CFG_THREE_Q_A, `AECR_CFG_THREE_Q_B: phys_raw[j*16 +: 16] = `AECR_LVL_THREE_Q;
        `AECR_CFG_HALF: phys_raw[j*16 +: 16] = `AECR_LVL_HALF;
        default: phys_raw[j*16 +: 16] = diff_sample(enc_p[j*16 +: 16], enc_n[j*16 +: 16]);
      endcase
    end
  end

  // Differential input folded to an unsigned sample around midscale.
  function [15:0] diff_sample;
    input [15:0] p;
    input [15:0] n;
    reg [16:0] d;
    begin
      d = {1'b0, p} - {1'b0, n};
      diff_sample = {~d[16], d[15:1]};
    end
  endfunction

  // Routing: an undefined code falls back to the U/X input.
  always @*
  begin
    sel_raw = 48'h000000000000;
    for (j = 0; j < 3; j = j + 1)
    begin
      case (routing_sel[j*8 +: 8])
        `AECR_SRC_V: sel_raw[j*16 +: 16] = phys_raw[31:16];
        `AECR_SRC_W: sel_raw[j*16 +: 16] = phys_raw[47:32];
        default: sel_raw[j*16 +: 16] = phys_raw[15:0];
      endcase
    end
  end

  // One corrector per encoder channel and one per phase current.
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : g_chan
      aecr_corrector u_enc
      (
        .clk_i(MCLK_I),
        .rst_n_i(RSTN_I),
        .valid_i(ENC_VALID_I),
        .raw_i(sel_raw[g*16 +: 16]),
        .offset_i(enc_cal_reg[g][`AECR_OFFSET_LSB +: 16]),
        .scale_i(enc_cal_reg[g][`AECR_SCALE_LSB +: 16]),
        .valid_o(enc_valid[g]),
        .value_o(enc_value[g*16 +: 16])
      );
      aecr_corrector u_cur
      (
        .clk_i(MCLK_I),
        .rst_n_i(RSTN_I),
        .valid_i(CUR_VALID_I),
        .raw_i(cur_raw[g*16 +: 16]),
        .offset_i(cur_cal_reg[g][`AECR_OFFSET_LSB +: 16]),
        .scale_i(cur_cal_reg[g][`AECR_SCALE_LSB +: 16]),
        .valid_o(cur_valid[g]),
        .value_o(cur_value[g*16 +: 16])
      );
    end
  endgenerate

  // Outputs come straight from the corrector flops, shared with the readback.
  assign ENC_VALID_O = enc_valid[0];
  assign ENC_CH0_O = enc_value[15:0];
  assign ENC_CH1_O = enc_value[31:16];
  assign ENC_CH2_O = enc_value[47:32];
  assign CUR_VALID_O = cur_valid[0];
  assign CUR_U_O = cur_value[15:0];
  assign CUR_V_O = cur_value[31:16];
  assign CUR_W_O = cur_value[47:32];

endmodule // aecr_top

// *** aecr_top_props.sv ***
`timescale 1ns/100ps
module aecr_top_props
(
  input wire logic MCLK_I, // Clock.
  input wire logic RSTN_I, // Reset, active low.
  input wire logic PSEL_I, // Select.
  input wire logic PENABLE_I, // Enable.
  input wire logic PREADY_O, // Ready.
  input wire logic PSLVERR_O, // Error.
  input wire logic [31:0] PRDATA_O, // Read data.
  input wire logic ENC_VALID_I, // Encoder strobe in.
  input wire logic ENC_VALID_O, // Encoder strobe out.
  input wire logic [15:0] ENC_CH0_O, // Channel 0.
  input wire logic [15:0] ENC_CH1_O, // Channel 1.
  input wire logic [15:0] ENC_CH2_O, // Channel 2.
  input wire logic CUR_VALID_I, // Current strobe in.
  input wire logic CUR_VALID_O, // Current strobe out.
  input wire logic [15:0] CUR_U_O, // Current U.
  input wire logic [15:0] CUR_V_O, // Current V.
  input wire logic [15:0] CUR_W_O // Current W.
);
  // One domain, so clock and reset are given once.
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RSTN_I);
  sequence s_setup; PSEL_I && !PENABLE_I; endsequence
  sequence s_wait; PSEL_I && PENABLE_I && !PREADY_O; endsequence
  property p_ready_lat; s_setup ##1 s_wait |=> PREADY_O; endproperty
  a_ready_lat: assert property (p_ready_lat) else $error("ready not after one wait");
  property p_ready_pulse; PREADY_O |=> !PREADY_O; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready too long");
  property p_ready_cause; PREADY_O |-> PSEL_I && $past(PENABLE_I); endproperty
  a_ready_cause: assert property (p_ready_cause) else $error("ready unasked");
  property p_err_zero; PSLVERR_O |-> PREADY_O && PRDATA_O == 32'h0; endproperty
  a_err_zero: assert property (p_err_zero) else $error("error with data");
  property p_enc_lat; ENC_VALID_I |=> ENC_VALID_O; endproperty
  a_enc_lat: assert property (p_enc_lat) else $error("encoder strobe lost");
  property p_enc_quiet; !ENC_VALID_I |=> !ENC_VALID_O; endproperty
  a_enc_quiet: assert property (p_enc_quiet) else $error("encoder strobe spurious");
  property p_enc_hold;
    !ENC_VALID_O |-> $stable(ENC_CH0_O) && $stable(ENC_CH1_O) && $stable(ENC_CH2_O);
  endproperty
  a_enc_hold: assert property (p_enc_hold) else $error("encoder value moved");
  property p_cur_lat; CUR_VALID_I |=> CUR_VALID_O; endproperty
  a_cur_lat: assert property (p_cur_lat) else $error("current strobe lost");
  property p_cur_quiet; !CUR_VALID_I |=> !CUR_VALID_O; endproperty
  a_cur_quiet: assert property (p_cur_quiet) else $error("current strobe spurious");
  property p_cur_hold;
    !CUR_VALID_O |-> $stable(CUR_U_O) && $stable(CUR_V_O) && $stable(CUR_W_O);
  endproperty
  a_cur_hold: assert property (p_cur_hold) else $error("current value moved");
endmodule // aecr_top_props
bind aecr_top aecr_top_props i_props (.MCLK_I, .RSTN_I, .PSEL_I, .PENABLE_I, .PREADY_O,
  .PSLVERR_O, .PRDATA_O, .ENC_VALID_I, .ENC_VALID_O, .ENC_CH0_O, .ENC_CH1_O, .ENC_CH2_O,
  .CUR_VALID_I, .CUR_VALID_O, .CUR_U_O, .CUR_V_O, .CUR_W_O);

// *** aecr_top_tb.sv ***
`timescale 1ns/100ps
module aecr_top_tb;
  logic clk, rstn, psel, pen, pwr, ready, err, ev, cv, evo, cvo;
  logic [11:0] paddr;
  logic [31:0] pwd, prd, rt, cfg;
  logic [95:0] ed;
  logic [47:0] cd, cs;
  logic [95:0] es;
  logic [15:0] e0, e1, e2, eu, ev_, ew;
  logic [31:0] cal [3];
  logic [63:0] exp_q [$];
  int failures = 0, n_tests = 0, cyc = 0;
  aecr_adc_model i_adc (.clk_i(clk), .enc_valid_o(ev), .enc_o(ed), .cur_valid_o(cv), .cur_o(cd));
  aecr_top i_dut (.MCLK_I(clk), .RSTN_I(rstn), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
    .PADDR_I(paddr), .PWDATA_I(pwd), .PREADY_O(ready), .PSLVERR_O(err), .PRDATA_O(prd),
    .ENC_VALID_I(ev), .ENC_U_P_I(ed[15:0]), .ENC_U_N_I(ed[31:16]), .ENC_V_P_I(ed[47:32]),
    .ENC_V_N_I(ed[63:48]), .ENC_W_P_I(ed[79:64]), .ENC_W_N_I(ed[95:80]), .CUR_VALID_I(cv),
    .CUR_U_RAW_I(cd[15:0]), .CUR_V_RAW_I(cd[31:16]), .CUR_W_RAW_I(cd[47:32]),
    .ENC_VALID_O(evo), .ENC_CH0_O(e0), .ENC_CH1_O(e1), .ENC_CH2_O(e2), .CUR_VALID_O(cvo),
    .CUR_U_O(eu), .CUR_V_O(ev_), .CUR_W_O(ew));
  // Clock at 250 MHz.
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Source picked by the input configuration code, returned as a signed sample.
  function automatic logic signed [16:0] src(input logic [3:0] c, input logic [15:0] p, n);
    logic [16:0] d;
    logic [15:0] r;
    d = {1'b0, p} - {1'b0, n};
    case (c)
      4'h1: r = ~n;
      4'h4: r = p;
      4'h2, 4'h6: r = 16'h4000;
      4'h3, 4'h7: r = 16'hc000;
      4'h5: r = 16'h8000;
      default: r = {~d[16], d[15:1]};
    endcase
    return {~r[15], ~r[15], r[14:0]};
  endfunction
  // Offset added, scaled with unity at 256, saturated.
  function automatic logic [15:0] corr(input logic signed [16:0] x, input logic [31:0] c);
    logic signed [35:0] p;
    p = (x + $signed(c[15:0])) * $signed(c[31:16]);
    p = p >>> 8;
    if (p > 36'sh7fff) return 16'h7fff;
    if (p < -36'sh8000) return 16'h8000;
    return p[15:0];
  endfunction
  // One APB transfer; a read notes its expected error flag and data first.
  task apb(input logic w, input logic [7:0] idx, input logic [31:0] d, input logic [32:0] x);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= {2'h0, idx, 2'h0};
    pwd <= d;
    if (!w) exp_q.push_back({31'h0, x});
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (ready !== 1'b1);
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task chk(input string what, input logic [63:0] seen);
    logic [63:0] x;
    n_tests++;
    x = exp_q.size() ? exp_q.pop_front() : 64'hx;
    if (seen !== x)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", what, x, seen);
    end
  endtask
  // Results are matched against the oldest note as they appear.
  always @(posedge clk)
  begin
    if (rstn && psel && pen && ready === 1'b1 && pwr === 1'b0) chk("read", {31'h0, err, prd});
    if (evo === 1'b1) chk("encoder", {16'h0, e2, e1, e0});
    if (cvo === 1'b1) chk("current", {16'h0, ew, ev_, eu});
  end
  // A hang ends the run as a failure.
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      failures++;
      conclude();
    end
  end
  task conclude();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Reset values, an unmapped word, then randomised calibration rounds per config code.
  initial
  begin
    {rstn, psel, pen, pwr, paddr, pwd} = '0;
    void'($urandom(57));
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    for (int k = 0; k < 3; k++) apb(0, 8'h0d + k, 0, {1'b0, 32'h01000000});
    apb(0, 8'h11, 0, {1'b0, 32'h00020100});
    apb(0, 8'h12, 0, 33'h0);
    apb(0, 8'h10, 0, {1'b1, 32'h0});
    $display("reset values done");
    for (int i = 0; i < 8; i++)
    begin
      logic signed [16:0] ph [3];
      logic [15:0] v [3];
      for (int k = 0; k < 3; k++)
      begin
        cal[k] = $urandom;
        apb(1, 8'h0d + k, cal[k], 0);
        rt[8*k +: 8] = 8'($urandom % 4);
      end
      rt[31:24] = 8'h0;
      apb(1, 8'h11, rt, 0);
      cfg = {i[3:0], i[3:0], i[3:0], 20'h0};
      apb(1, 8'h0a, cfg, 0);
      apb(0, 8'h0d + 8'(i % 3), 0, {1'b0, cal[i % 3]});
      apb(0, 8'h11, 0, {1'b0, rt});
      es = {$urandom, $urandom, $urandom};
      for (int k = 0; k < 3; k++) ph[k] = src(i[3:0], es[32*k +: 16], es[32*k+16 +: 16]);
      for (int k = 0; k < 3; k++) v[k] = corr(ph[rt[8*k +: 8] > 2 ? 0 : rt[8*k +: 2]], cal[k]);
      exp_q.push_back({16'h0, v[2], v[1], v[0]});
      i_adc.send_enc(es);
      apb(0, 8'h15, 0, {1'b0, v[2], v[0]});
      apb(0, 8'h16, 0, {1'b0, 16'h0, v[1]});
      for (int k = 0; k < 3; k++)
      begin
        cal[k] = $urandom;
        apb(1, 8'h20 + k, cal[k], 0);
      end
      cs = 48'({$urandom, $urandom});
      for (int k = 0; k < 3; k++) v[k] = corr(src(4'h4, cs[16*k +: 16], 16'h0), cal[k]);
      exp_q.push_back({16'h0, v[2], v[1], v[0]});
      i_adc.send_cur(cs);
      apb(0, 8'h12, 0, {1'b0, v[2], v[0]});
      apb(0, 8'h13, 0, {1'b0, 16'h0, v[1]});
      $display("round %0d done", i);
    end
    repeat (4) @(posedge clk);
    conclude();
  end
endmodule // aecr_top_tb
